// ==== common/pbm_pkg.sv ====
// constants and types shared by the port b pin function mux
package pbm_pkg;
  localparam int PBM_W   = 8;
  localparam int ST_W    = 5;
  localparam int NEXT    = 4;
  localparam int CHG_LO  = 4;
  localparam int CHG_W   = 4;
  localparam int FLT_PIN = 0;
  localparam int CCP_PIN = 3;
  localparam int CLK_PIN = 6;
  localparam int DAT_PIN = 7;

  localparam logic [7:0] A_LATCH = 8'h00;
  localparam logic [7:0] A_DIR   = 8'h04;
  localparam logic [7:0] A_PIN   = 8'h08;
  localparam logic [7:0] A_CTRL  = 8'h0c;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam logic [7:0] A_MASK  = 8'h14;

  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'hff;
  localparam logic [3:0] RST_CTRL  = 4'h5;
  localparam logic [3:0] DBG_CHG   = 4'hc;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic pwm2a_tristate;
    logic capcomp2_pin_select;
    logic fault_enable;
    logic pullup_disable_n;
  } pbm_ctrl_t;

  typedef struct packed {
    logic ccp2_out;
    logic ccp2_drive;
    logic pwm2a_out;
    logic pwm2a_drive;
    logic pwm2_shutdown;
    logic debug_en;
    logic debug_data_out;
    logic debug_data_drive;
  } pbm_periph_t;

  typedef struct packed {
    logic [NEXT-1:0] ext_irq;
    logic            fault;
    logic            capture;
    logic            dbg_clk;
    logic            dbg_data;
  } pbm_func_t;

  typedef struct packed {
    logic [PBM_W-1:0] latch;
    logic [PBM_W-1:0] dir;
    pbm_ctrl_t        ctrl;
    logic [ST_W-1:0]  status;
    logic [ST_W-1:0]  mask;
    logic [CHG_W-1:0] old_chg;
    logic [NEXT-1:0]  ext_prev;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic             irq;
    logic [PBM_W-1:0] pin_out;
    logic [PBM_W-1:0] pin_oe_n;
    logic [PBM_W-1:0] pullup_en;
    pbm_func_t        func;
  } pbm_state_t;
endpackage

// ==== design/pbm_sync.sv ====
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module pbm_sync
  import pbm_pkg::*;
#(
  parameter int W = PBM_W
)(
  input  wire logic         hclk,    // clock
  input  wire logic         hresetn, // async reset
  input  wire logic [W-1:0] din,     // raw pin levels
  output logic      [W-1:0] q        // filtered levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pbm_sync_state_t;

  pbm_sync_state_t s;
  pbm_sync_state_t next_s;

  always_comb
  begin
    next_s    = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // take a new level only when stages two and three agree
    next_s.q  = (s.s2 & s.s3) | (s.q & (s.s2 | s.s3));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.q;
endmodule // pbm_sync

// ==== design/pbm_pin_mux.sv ====
// per-pin function selection for the eight port pins
`timescale 1ns/1ps
module pbm_pin_mux
  import pbm_pkg::*;
(
  input  wire logic [PBM_W-1:0] dir,       // direction_bits, 1 = input
  input  wire logic [PBM_W-1:0] latch,     // output_latch
  input  wire logic [PBM_W-1:0] pin_s,     // synchronised pin levels
  input  wire pbm_ctrl_t        ctrl,      // control bits
  input  wire pbm_periph_t      periph,    // peripheral drive requests
  output logic      [PBM_W-1:0] pin_out,   // level to drive
  output logic      [PBM_W-1:0] pin_drive, // 1 = driver on
  output logic      [PBM_W-1:0] pull_on,   // weak pull-up on
  output logic      [CHG_W-1:0] chg_en,    // change compare enables
  output pbm_func_t             func       // inputs to peripherals
);
  always_comb
  begin
    pin_out   = latch;
    pin_drive = ~dir;
    pull_on   = dir & {PBM_W{~ctrl.pullup_disable_n}};
    chg_en    = dir[PBM_W-1:CHG_LO];
    func      = '0;
    func.ext_irq = dir[NEXT-1:0] & pin_s[NEXT-1:0];
    func.fault   = dir[FLT_PIN] & ctrl.fault_enable & pin_s[FLT_PIN];
    if (!ctrl.capcomp2_pin_select)
    begin
      if (!dir[CCP_PIN])
      begin
        if (periph.pwm2a_drive)
        begin
          pin_out[CCP_PIN]   = periph.pwm2a_out;
          pin_drive[CCP_PIN] = ~(periph.pwm2_shutdown & ctrl.pwm2a_tristate);
        end
        else if (periph.ccp2_drive)
          pin_out[CCP_PIN] = periph.ccp2_out;
      end
      else
        func.capture = pin_s[CCP_PIN];
    end
    func.dbg_clk  = pin_s[CLK_PIN];
    func.dbg_data = pin_s[DAT_PIN];
    if (periph.debug_en)
    begin
      pin_drive[CLK_PIN] = 1'b0;
      pull_on[CLK_PIN]   = 1'b0;
      pull_on[DAT_PIN]   = 1'b0;
      pin_out[DAT_PIN]   = periph.debug_data_out;
      pin_drive[DAT_PIN] = periph.debug_data_drive;
      chg_en             = chg_en & ~DBG_CHG;
    end
  end
endmodule // pbm_pin_mux

// ==== design/pbm_port_b.sv ====
// port b with ahb-lite registers, pin muxing and change interrupt
`timescale 1ns/1ps
// Notes on behaviour
// - direction 0 with no override drives the output latch bit onto the pin.
// - direction 1 reads the pin; pull-up on while pull-up disable bit is low.
// - pins 0..3 feed external interrupt inputs 0..3 when set as inputs.
// - pin 0 feeds the pwm fault input when input and enabled by software.
// - mapped capture/compare two drives pin 3 as output, captures it as input.
// - mapped pwm two channel a wins over port data; may float on shutdown.
// - capture/compare two and pwm a reach pin 3 only when pin select is low.
// - pin 6 is the debug serial clock input whatever its direction.
// - pin 7 is the debug serial data line, direction set by debug logic.
// - debug enabled removes every other function from pins 6 and 7.
// - functions not tied to direction ignore or override the direction bit.
// - pins 4..7 set as inputs can raise the port change interrupt.
// - change inputs compare against value latched at last port read or port pin write; mismatches or.
// - one active-low bit enables all eight pull-ups together.
// - a pin set as output never has its pull-up on.
module pbm_port_b
  import pbm_pkg::*;
(
  input  wire logic             hclk,      // bus clock, 40 mhz
  input  wire logic             hresetn,   // async reset
  input  wire logic             hsel,      // slave select
  input  wire logic [31:0]      haddr,     // byte address
  input  wire logic [1:0]       htrans,    // transfer type
  input  wire logic             hwrite,    // write access
  input  wire logic [2:0]       hsize,     // transfer size
  input  wire logic [31:0]      hwdata,    // write data
  input  wire logic             hready,    // bus ready in
  output logic      [31:0]      hrdata,    // read data
  output logic                  hreadyout, // slave ready
  output logic                  hresp,     // always okay
  output logic                  irq,       // level interrupt
  input  wire logic [PBM_W-1:0] pin_in,    // pin levels
  output logic      [PBM_W-1:0] pin_out,   // pin drive levels
  output logic      [PBM_W-1:0] pin_oe_n,  // low while driving
  output logic      [PBM_W-1:0] pullup_en, // weak pull-up enables
  input  wire pbm_periph_t      periph,    // peripheral requests
  output pbm_func_t             func       // peripheral inputs
);
  pbm_state_t       s;
  pbm_state_t       next_s;
  logic [PBM_W-1:0] pin_s;
  logic [PBM_W-1:0] mx_out;
  logic [PBM_W-1:0] mx_drive;
  logic [PBM_W-1:0] mx_pullup;
  logic [CHG_W-1:0] mx_chg_en;
  pbm_func_t        mx_func;
  logic             acc;
  logic [7:0]       aoff;
  logic             mismatch;
  logic [ST_W-1:0]  stat_clr;

  pbm_sync #(.W(PBM_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pin_in),
    .q       (pin_s)
  );

  pbm_pin_mux u_mux (
    .dir       (s.dir),
    .latch     (s.latch),
    .pin_s     (pin_s),
    .ctrl      (s.ctrl),
    .periph    (periph),
    .pin_out   (mx_out),
    .pin_drive (mx_drive),
    .pull_on   (mx_pullup),
    .chg_en    (mx_chg_en),
    .func      (mx_func)
  );

  function automatic logic [31:0] rd_word(input logic [7:0] a, input pbm_state_t r, input logic [PBM_W-1:0] p);
    logic [31:0] v;
    v = '0;
    if (a == A_LATCH)
      v[PBM_W-1:0] = r.latch;
    else if (a == A_DIR)
      v[PBM_W-1:0] = r.dir;
    else if (a == A_PIN)
      v[PBM_W-1:0] = p;
    else if (a == A_CTRL)
      v[3:0] = r.ctrl;
    else if (a == A_STAT)
      v[ST_W-1:0] = r.status;
    else if (a == A_MASK)
      v[ST_W-1:0] = r.mask;
    return v;
  endfunction

  assign acc      = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
  assign aoff     = haddr[7:0];
  assign mismatch = |((pin_s[PBM_W-1:CHG_LO] ^ s.old_chg) & mx_chg_en);
  assign stat_clr = (s.wr_pend && s.wr_addr == A_STAT) ? hwdata[ST_W-1:0] : '0;

  always_comb
  begin
    next_s = s;
    // data phase of a write
    if (s.wr_pend)
    begin
      if (s.wr_addr == A_LATCH)
        next_s.latch = hwdata[PBM_W-1:0];
      else if (s.wr_addr == A_DIR)
        next_s.dir = hwdata[PBM_W-1:0];
      else if (s.wr_addr == A_PIN)
      begin
        next_s.latch   = hwdata[PBM_W-1:0];
        next_s.old_chg = pin_s[PBM_W-1:CHG_LO];
      end
      else if (s.wr_addr == A_CTRL)
        next_s.ctrl = hwdata[3:0];
      else if (s.wr_addr == A_MASK)
        next_s.mask = hwdata[ST_W-1:0];
    end
    // set wins over write-one-to-clear
    next_s.ext_prev = mx_func.ext_irq;
    next_s.status   = (s.status & ~stat_clr) | {mx_func.ext_irq & ~s.ext_prev, mismatch};
    next_s.irq      = |(next_s.status & next_s.mask);
    // address phase
    next_s.wr_pend = acc & hwrite;
    next_s.wr_addr = aoff;
    if (acc && !hwrite)
    begin
      next_s.hrdata = rd_word(aoff, next_s, pin_s);
      if (aoff == A_PIN)
        next_s.old_chg = pin_s[PBM_W-1:CHG_LO];
    end
    next_s.hreadyout = 1'b1;
    next_s.hresp     = 1'b0;
    next_s.pin_out   = mx_out;
    next_s.pin_oe_n  = ~mx_drive;
    next_s.pullup_en = mx_pullup;
    next_s.func      = mx_func;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s           <= '0;
      s.latch     <= RST_LATCH;
      s.dir       <= RST_DIR;
      s.ctrl      <= RST_CTRL;
      s.pin_oe_n  <= RST_DIR;
      s.hreadyout <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign hrdata    = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp     = s.hresp;
  assign irq       = s.irq;
  assign pin_out   = s.pin_out;
  assign pin_oe_n  = s.pin_oe_n;
  assign pullup_en = s.pullup_en;
  assign func      = s.func;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_latch_drive;
    !s.dir[1] |=> !pin_oe_n[1] && pin_out[1] == $past(s.latch[1]);
  endproperty
  a_latch_drive: assert property (p_latch_drive) else $error("output pin does not follow latch");

  property p_input_pullup;
    s.dir[2] |=> pin_oe_n[2] && pullup_en[2] == !$past(s.ctrl.pullup_disable_n);
  endproperty
  a_input_pullup: assert property (p_input_pullup) else $error("input pin drive or pull-up wrong");

  property p_ext_irq;
    ##1 func.ext_irq == $past(s.dir[NEXT-1:0] & pin_s[NEXT-1:0]);
  endproperty
  a_ext_irq: assert property (p_ext_irq) else $error("external interrupt input wrong");

  property p_fault_gate;
    !s.ctrl.fault_enable |=> !func.fault;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault input active while disabled");

  property p_ccp_out;
    !s.ctrl.capcomp2_pin_select && !s.dir[CCP_PIN] && periph.ccp2_drive && !periph.pwm2a_drive
      |=> pin_out[CCP_PIN] == $past(periph.ccp2_out);
  endproperty
  a_ccp_out: assert property (p_ccp_out) else $error("compare output not on pin 3");

  property p_pwm_float;
    !s.ctrl.capcomp2_pin_select && !s.dir[CCP_PIN] && periph.pwm2a_drive && periph.pwm2_shutdown
      && s.ctrl.pwm2a_tristate |=> pin_oe_n[CCP_PIN];
  endproperty
  a_pwm_float: assert property (p_pwm_float) else $error("pwm a still driven in shutdown");

  property p_default_map;
    s.ctrl.capcomp2_pin_select && !s.dir[CCP_PIN] |=> pin_out[CCP_PIN] == $past(s.latch[CCP_PIN]) && !func.capture;
  endproperty
  a_default_map: assert property (p_default_map) else $error("pin 3 taken while not mapped");

  property p_dbg_clk;
    ##1 func.dbg_clk == $past(pin_s[CLK_PIN]);
  endproperty
  a_dbg_clk: assert property (p_dbg_clk) else $error("debug clock not from pin 6");

  property p_dbg_data;
    periph.debug_en |=> pin_oe_n[DAT_PIN] == !$past(periph.debug_data_drive);
  endproperty
  a_dbg_data: assert property (p_dbg_data) else $error("pin 7 direction not from debug");

  property p_dbg_excl;
    periph.debug_en |=> pin_oe_n[CLK_PIN] && !pullup_en[CLK_PIN] && !pullup_en[DAT_PIN];
  endproperty
  a_dbg_excl: assert property (p_dbg_excl) else $error("other function left on debug pins");

  property p_change_set;
    s.dir[CHG_LO] && (pin_s[CHG_LO] != s.old_chg[0]) |=> s.status[0];
  endproperty
  a_change_set: assert property (p_change_set) else $error("port change flag not set");

  property p_out_no_pullup;
    !s.dir[5] |=> !pullup_en[5];
  endproperty
  a_out_no_pullup: assert property (p_out_no_pullup) else $error("pull-up on an output pin");

  property p_port_latch;
    s.ctrl.capcomp2_pin_select && !periph.debug_en && s.dir == '0
      |=> pin_out == $past(s.latch) && pin_oe_n == '0;
  endproperty
  a_port_latch: assert property (p_port_latch) else $error("port pins do not follow latch");

  property p_pullup_off;
    s.ctrl.pullup_disable_n |=> pullup_en == '0;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up on while disabled");

  property p_pullup_on;
    !s.ctrl.pullup_disable_n && s.dir[CHG_LO] |=> pullup_en[CHG_LO];
  endproperty
  a_pullup_on: assert property (p_pullup_on) else $error("pull-up off on enabled input");

  property p_no_pullup_out;
    ##1 (pullup_en & ~$past(s.dir)) == '0;
  endproperty
  a_no_pullup_out: assert property (p_no_pullup_out) else $error("pull-up on an output pin");

  property p_change_excl;
    s.dir[PBM_W-1:CHG_LO] == '0 && !s.status[0] |=> !s.status[0];
  endproperty
  a_change_excl: assert property (p_change_excl) else $error("output pin raised change flag");

  property p_dbg_no_change;
    periph.debug_en && s.dir[CHG_LO+1:CHG_LO] == '0 && !s.status[0] |=> !s.status[0];
  endproperty
  a_dbg_no_change: assert property (p_dbg_no_change) else $error("debug pin raised change flag");

  property p_dbg_clk_float;
    periph.debug_en && !s.dir[CLK_PIN] |=> pin_oe_n[CLK_PIN];
  endproperty
  a_dbg_clk_float: assert property (p_dbg_clk_float) else $error("debug clock pin driven");

  property p_dbg_data_out;
    periph.debug_en && periph.debug_data_drive |=> pin_out[DAT_PIN] == $past(periph.debug_data_out);
  endproperty
  a_dbg_data_out: assert property (p_dbg_data_out) else $error("debug data level not on pin 7");

  property p_capture;
    !s.ctrl.capcomp2_pin_select && s.dir[CCP_PIN] |=> func.capture == $past(pin_s[CCP_PIN]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture input not from pin 3");

  property p_pwm_prio;
    !s.ctrl.capcomp2_pin_select && !s.dir[CCP_PIN] && periph.pwm2a_drive
      |=> pin_out[CCP_PIN] == $past(periph.pwm2a_out);
  endproperty
  a_pwm_prio: assert property (p_pwm_prio) else $error("pwm a level not on pin 3");

  property p_fault_pass;
    s.ctrl.fault_enable && s.dir[FLT_PIN] |=> func.fault == $past(pin_s[FLT_PIN]);
  endproperty
  a_fault_pass: assert property (p_fault_pass) else $error("fault input not from pin 0");

  property p_irq_change;
    s.status[0] && s.mask[0] |-> irq;
  endproperty
  a_irq_change: assert property (p_irq_change) else $error("change flag unmasked but no interrupt");

  property p_change_read;
    acc && !hwrite && aoff == A_PIN |=> s.old_chg == $past(pin_s[PBM_W-1:CHG_LO]);
  endproperty
  a_change_read: assert property (p_change_read) else $error("change reference not taken on read");

  property p_pin_read;
    acc && !hwrite && aoff == A_PIN |=> hrdata[PBM_W-1:0] == $past(pin_s);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read data not synchronised level");

  c_change_irq: cover property (s.mask[0] && !s.status[0] ##1 s.status[0] ##1 irq);
  c_capture: cover property (!s.ctrl.capcomp2_pin_select && s.dir[CCP_PIN] && func.capture);
  c_debug_drive: cover property (periph.debug_en && !pin_oe_n[DAT_PIN]);
  c_pin_read: cover property (acc && !hwrite && aoff == A_PIN);
  c_pwm_on_pin3: cover property (!s.ctrl.capcomp2_pin_select && !s.dir[CCP_PIN] && periph.pwm2a_drive);
endmodule // pbm_port_b

// ==== tb/pbm_ext_pins.sv ====
// far-side circuitry on the eight port pins
`timescale 1ns/1ps
module pbm_ext_pins
  import pbm_pkg::*;
(
  input  wire logic             hclk,      // clock
  input  wire logic [PBM_W-1:0] pin_out,   // device drive level
  input  wire logic [PBM_W-1:0] pin_oe_n,  // device drives while low
  input  wire logic [PBM_W-1:0] pullup_en, // device weak pull-up
  input  wire logic [PBM_W-1:0] ext_val,   // far side level
  input  wire logic [PBM_W-1:0] ext_en,    // far side drives
  output logic      [PBM_W-1:0] pin_wire   // resolved pin level
);
  logic [PBM_W-1:0] last;

  always_ff @(posedge hclk)
    last <= pin_wire;

  // undriven pin with no pull-up wanders every cycle
  always_comb
    for (int i = 0; i < PBM_W; i++)
      if (!pin_oe_n[i])
        pin_wire[i] = pin_out[i];
      else if (ext_en[i])
        pin_wire[i] = ext_val[i];
      else if (pullup_en[i])
        pin_wire[i] = 1'b1;
      else
        pin_wire[i] = ~last[i];
endmodule // pbm_ext_pins

// ==== tb/pbm_port_b_tb.sv ====
// self-checking bench for the port b pin function mux
`timescale 1ns/1ps
module pbm_port_b_tb
  import pbm_pkg::*;
;
  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, hrdata, rdat;
  logic [PBM_W-1:0] pin_in, pin_out, pin_oe_n, pullup_en, ext_val, ext_en;
  pbm_periph_t      periph;
  pbm_func_t        func;
  int               n_errors, n_tests, cyc;

  always #12.5 hclk = ~hclk;

  pbm_port_b uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .periph(periph), .func(func));
  pbm_ext_pins ext (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .ext_val(ext_val), .ext_en(ext_en), .pin_wire(pin_in));

  task automatic test_done();
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single word transfer, read data left in rdat
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdat = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task automatic t_reset();
    chk(32'({pin_oe_n, pullup_en}), 32'h0000ff00);
    chk(32'({hresp, hreadyout}), 32'h1);
    rdchk(A_LATCH, 32'(RST_LATCH));
    rdchk(A_DIR, 32'(RST_DIR));
    rdchk(A_CTRL, 32'(RST_CTRL));
    rdchk(A_STAT, 32'h0);
    rdchk(A_MASK, 32'h0);
    rdchk(8'h18, 32'h0);
  endtask

  task automatic t_drive();
    bus(1'b1, A_CTRL, 32'h4);
    bus(1'b1, A_DIR, 32'h0);
    bus(1'b1, A_LATCH, 32'ha5);
    rdchk(A_LATCH, 32'ha5);
    wt(8);
    chk(32'({pin_oe_n, pin_out}), 32'h00a5);
    chk(32'(pullup_en), 32'h0);
    rdchk(A_PIN, 32'ha5);
    rdchk(A_STAT, 32'h0);
  endtask

  task automatic t_pullup();
    ext_en <= 8'h0f;
    bus(1'b1, A_DIR, 32'hf0);
    wt(8);
    chk(32'(pullup_en), 32'hf0);
    rdchk(A_PIN, 32'hf5);
    bus(1'b1, A_CTRL, 32'h5);
    wt(3);
    chk(32'(pullup_en), 32'h0);
    ext_en <= 8'hff;
    ext_val <= 8'h00;
  endtask

  task automatic t_irq();
    bus(1'b1, A_DIR, 32'h0f);
    bus(1'b1, A_MASK, 32'h1e);
    rdchk(A_MASK, 32'h1e);
    wt(8);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, A_STAT, 32'h1f);
      ext_val <= 8'(1 << i);
      wt(8);
      chk(32'(func.ext_irq), 32'(1 << i));
      rdchk(A_STAT, 32'(2 << i));
      chk(32'(irq), 32'h1);
    end
    bus(1'b1, A_MASK, 32'h0);
    wt(2);
    chk(32'(irq), 32'h0);
    bus(1'b1, A_MASK, 32'h1e);
    bus(1'b1, A_STAT, 32'h1f);
    wt(2);
    chk(32'(irq), 32'h0);
  endtask

  task automatic t_fault();
    ext_val <= 8'h01;
    wt(8);
    chk(32'(func.fault), 32'h0);
    bus(1'b1, A_CTRL, 32'h7);
    wt(3);
    chk(32'(func.fault), 32'h1);
  endtask

  task automatic t_ccp();
    bus(1'b1, A_DIR, 32'h07);
    bus(1'b1, A_LATCH, 32'h0);
    periph <= 8'hc0;
    wt(3);
    chk(32'(pin_out[CCP_PIN]), 32'h0);
    bus(1'b1, A_CTRL, 32'h3);
    wt(3);
    chk(32'({pin_oe_n[CCP_PIN], pin_out[CCP_PIN]}), 32'h1);
    periph <= 8'hd0;
    wt(3);
    chk(32'(pin_out[CCP_PIN]), 32'h0);
    periph <= 8'hd8;
    bus(1'b1, A_CTRL, 32'hb);
    wt(3);
    chk(32'(pin_oe_n[CCP_PIN]), 32'h1);
    periph <= 8'h40;
    ext_val <= 8'h08;
    bus(1'b1, A_DIR, 32'h0f);
    wt(8);
    chk(32'({pin_oe_n[CCP_PIN], func.capture}), 32'h3);
  endtask

  task automatic t_debug();
    periph <= 8'h05;
    bus(1'b1, A_CTRL, 32'h5);
    bus(1'b1, A_DIR, 32'h0);
    bus(1'b1, A_LATCH, 32'hff);
    wt(3);
    chk(32'({pin_oe_n[7:6], pin_out[DAT_PIN]}), 32'h2);
    periph <= 8'h04;
    ext_val <= 8'hc0;
    bus(1'b1, A_DIR, 32'hf0);
    wt(8);
    chk(32'({pin_oe_n[DAT_PIN], func.dbg_clk, func.dbg_data}), 32'h7);
    bus(1'b0, A_PIN, 32'h0);
    bus(1'b1, A_STAT, 32'h1f);
    ext_val <= 8'h00;
    wt(8);
    rdchk(A_STAT, 32'h0);
  endtask

  task automatic t_change();
    periph <= 8'h00;
    wt(8);
    bus(1'b0, A_PIN, 32'h0);
    bus(1'b1, A_STAT, 32'h1f);
    rdchk(A_STAT, 32'h0);
    bus(1'b1, A_MASK, 32'h1f);
    chk(32'(irq), 32'h0);
    ext_val <= 8'h20;
    wt(8);
    rdchk(A_STAT, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b1, A_STAT, 32'h1);
    rdchk(A_STAT, 32'h1);
    rdchk(A_PIN, 32'h2f);
    bus(1'b1, A_STAT, 32'h1);
    rdchk(A_STAT, 32'h0);
    chk(32'(irq), 32'h0);
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      test_done();
    end
  end

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    ext_val = 8'h00;
    ext_en = 8'hff;
    periph = 8'h00;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wt(2);
    t_reset();
    t_drive();
    t_pullup();
    t_irq();
    t_fault();
    t_ccp();
    t_debug();
    t_change();
    test_done();
  end
endmodule // pbm_port_b_tb
